// ---- src/adx_pkg.sv ----
package adx_pkg;

  // Clock and timing, times in ns
  localparam int CLK_NS = 20;
  localparam int PWRUP_NS = 500000;
  localparam int REF_WIN_NS = 16400000;
  localparam int REF_ROWS = 1024;
  localparam int INIT_CYCLES = 8;
  localparam int T_RP_NS = 60;
  localparam int T_CSR_NS = 10;
  localparam int T_RAS_NS = 80;
  localparam int T_CAS_NS = 60;

  // Least times round up, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PWRUP_CYC = cyc_min(PWRUP_NS);
  // Longest spacing between refreshes rounds down
  localparam int REF_CYC = REF_WIN_NS / REF_ROWS / CLK_NS;
  localparam int RP_CYC = cyc_min(T_RP_NS);
  localparam int CSR_CYC = cyc_min(T_CSR_NS);
  localparam int RAS_CYC = cyc_min(T_RAS_NS);
  localparam int CAS_CYC = cyc_min(T_CAS_NS);

  // Geometry
  localparam int ADDR_W = 20;
  localparam int PIN_ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int WAIT_W = 4;
  localparam int INIT_W = 4;

  typedef enum logic [3:0] {
    S_PWRUP   = 4'h0,
    S_CBR_CAS = 4'h1,
    S_CBR_RAS = 4'h2,
    S_PRECH   = 4'h3,
    S_IDLE    = 4'h4,
    S_ROW_SET = 4'h5,
    S_ROW_LAT = 4'h6,
    S_COL_SET = 4'h7,
    S_COL_ACT = 4'h8
  } adx_state_e;

  typedef struct packed {
    logic ras_n;
    logic lower_col_strobe_n;
    logic upper_col_strobe_n;
    logic we_n;
    logic oe_n;
    logic [PIN_ADDR_W-1:0] addr;
  } adx_pins_s;

  localparam adx_pins_s PINS_IDLE = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 10'h000};

endpackage

// ---- src/adx_interval_timer.sv ----
`timescale 1ns/1ns
module adx_interval_timer #(
  parameter int W = 16,
  parameter logic [W-1:0] PERIOD = 16'h0320
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);

  logic [W-1:0] count_r;
  logic tick_r;
  wire last = (count_r == PERIOD - W'(1));
  wire [W-1:0] count_nxt = !run ? '0 : (last ? '0 : count_r + W'(1));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= '0;
      tick_r <= 1'h0;
    end
    else
    begin
      count_r <= count_nxt;
      tick_r <= run && last;
    end
  end

  assign tick = tick_r;

endmodule

// ---- src/adx_dram_ctrl.sv ----
// Contract
// - Controller refreshes all 1024 rows every 16.4 ms.
// - After power-up wait 500 us, then eight row strobe cycles.
// - Row strobe toggling during the pause is allowed but not counted.
// - After over 16.4 ms row strobe idle, issue eight cycles first.
// - Use eight column-before-row cycles before relying on that refresh.
`timescale 1ns/1ns
module adx_dram_ctrl #(
  parameter int PWRUP_CYC = adx_pkg::PWRUP_CYC,
  parameter int REF_CYC = adx_pkg::REF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [adx_pkg::LANES-1:0] req_be,
  input wire logic [adx_pkg::ADDR_W-1:0] req_addr,
  input wire logic [adx_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [adx_pkg::DATA_W-1:0] rsp_rdata,
  output logic init_done,
  output adx_pkg::adx_pins_s pins,
  input wire logic [adx_pkg::DATA_W-1:0] dq_in,
  output logic [adx_pkg::DATA_W-1:0] dq_out,
  output logic [adx_pkg::LANES-1:0] dq_oe
);

  localparam int LANES = adx_pkg::LANES;
  localparam int LW = adx_pkg::LANE_W;
  localparam int WW = adx_pkg::WAIT_W;
  localparam int PAW = adx_pkg::PIN_ADDR_W;

  adx_pkg::adx_state_e state_r, state_nxt;
  logic [WW-1:0] wait_r, wait_nxt;
  logic [adx_pkg::INIT_W-1:0] init_cnt_r;
  logic pwr_done_r, ref_pend_r, req_ready_r, rsp_valid_r;
  logic wr_r;
  logic [LANES-1:0] be_r;
  logic [adx_pkg::ADDR_W-1:0] addr_r;
  logic [adx_pkg::DATA_W-1:0] wdata_r, rdata_r, rdata_nxt;
  adx_pkg::adx_pins_s pins_r, pins_nxt;
  logic [LANES-1:0] dq_oe_r, dq_oe_nxt, lane_cas;
  wire pwr_tick, ref_tick;

  adx_interval_timer #(.W(16), .PERIOD(16'(PWRUP_CYC))) u_pwrup (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(!pwr_done_r),
    .tick(pwr_tick)
  );

  adx_interval_timer #(.W(16), .PERIOD(16'(REF_CYC))) u_refresh (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(pwr_done_r),
    .tick(ref_tick)
  );

  wire taken = req_valid && req_ready_r;
  wire wait_done = (wait_r == '0);
  wire init_full = (init_cnt_r == adx_pkg::INIT_W'(adx_pkg::INIT_CYCLES));
  wire [WW-1:0] ld_rp = WW'(adx_pkg::RP_CYC - 1);
  wire [WW-1:0] ld_csr = WW'(adx_pkg::CSR_CYC - 1);
  wire [WW-1:0] ld_ras = WW'(adx_pkg::RAS_CYC - 1);
  wire [WW-1:0] ld_cas = WW'(adx_pkg::CAS_CYC - 1);

  always_comb
  begin
    state_nxt = state_r;
    wait_nxt = wait_done ? '0 : wait_r - WW'(1);
    unique case (state_r)
      adx_pkg::S_PWRUP:
        if (pwr_done_r)
        begin
          state_nxt = adx_pkg::S_CBR_CAS;
          wait_nxt = ld_csr;
        end
      adx_pkg::S_CBR_CAS:
        if (wait_done)
        begin
          state_nxt = adx_pkg::S_CBR_RAS;
          wait_nxt = ld_ras;
        end
      adx_pkg::S_CBR_RAS:
        if (wait_done)
        begin
          state_nxt = adx_pkg::S_PRECH;
          wait_nxt = ld_rp;
        end
      adx_pkg::S_PRECH:
        if (wait_done)
        begin
          if (!init_full)
          begin
            state_nxt = adx_pkg::S_CBR_CAS;
            wait_nxt = ld_csr;
          end
          else
            state_nxt = adx_pkg::S_IDLE;
        end
      adx_pkg::S_IDLE:
        if (taken)
          state_nxt = adx_pkg::S_ROW_SET;
        else if (ref_pend_r)
        begin
          state_nxt = adx_pkg::S_CBR_CAS;
          wait_nxt = ld_csr;
        end
      adx_pkg::S_ROW_SET:
        state_nxt = adx_pkg::S_ROW_LAT;
      adx_pkg::S_ROW_LAT:
        state_nxt = adx_pkg::S_COL_SET;
      adx_pkg::S_COL_SET:
      begin
        state_nxt = adx_pkg::S_COL_ACT;
        wait_nxt = ld_cas;
      end
      adx_pkg::S_COL_ACT:
        if (wait_done)
        begin
          state_nxt = adx_pkg::S_PRECH;
          wait_nxt = ld_rp;
        end
      default:
      begin
        state_nxt = adx_pkg::S_PWRUP;
        wait_nxt = '0;
      end
    endcase
  end

  // Pin decode from the next state
  wire cbr_nxt = (state_nxt == adx_pkg::S_CBR_CAS) || (state_nxt == adx_pkg::S_CBR_RAS);
  wire col_nxt = (state_nxt == adx_pkg::S_COL_SET) || (state_nxt == adx_pkg::S_COL_ACT);
  wire act_nxt = (state_nxt == adx_pkg::S_COL_ACT);
  wire ras_nxt = col_nxt || (state_nxt == adx_pkg::S_ROW_LAT)
    || (state_nxt == adx_pkg::S_CBR_RAS);
  wire last_col = (state_r == adx_pkg::S_COL_ACT) && wait_done;
  wire ref_clear = (state_nxt == adx_pkg::S_CBR_CAS) && (state_r != adx_pkg::S_CBR_CAS);
  wire ref_pend_nxt = ref_tick || (ref_pend_r && !ref_clear);
  // Row address goes out at the taken edge, ahead of the row strobe
  wire [adx_pkg::ADDR_W-1:0] addr_src = taken ? req_addr : addr_r;
  wire [PAW-1:0] row_addr = addr_src[adx_pkg::ADDR_W-1:PAW];
  wire [PAW-1:0] col_addr = addr_src[PAW-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      assign lane_cas[gi] = cbr_nxt || (act_nxt && be_r[gi]);
      assign dq_oe_nxt[gi] = col_nxt && wr_r && be_r[gi];
      assign rdata_nxt[gi*LW +: LW] = be_r[gi] ? dq_in[gi*LW +: LW] : '0;
    end
  endgenerate

  assign pins_nxt.ras_n = !ras_nxt;
  assign pins_nxt.lower_col_strobe_n = !lane_cas[0];
  assign pins_nxt.upper_col_strobe_n = !lane_cas[1];
  assign pins_nxt.we_n = !(col_nxt && wr_r);
  assign pins_nxt.oe_n = !(act_nxt && !wr_r);
  assign pins_nxt.addr = col_nxt ? col_addr : row_addr;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= adx_pkg::S_PWRUP;
      wait_r <= '0;
      pins_r <= adx_pkg::PINS_IDLE;
      dq_oe_r <= '0;
      ref_pend_r <= 1'h0;
      req_ready_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      pins_r <= pins_nxt;
      dq_oe_r <= dq_oe_nxt;
      ref_pend_r <= ref_pend_nxt;
      req_ready_r <= (state_nxt == adx_pkg::S_IDLE) && !ref_pend_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_done_r <= 1'h0;
      init_cnt_r <= '0;
      rsp_valid_r <= 1'h0;
      rdata_r <= '0;
    end
    else
    begin
      pwr_done_r <= pwr_done_r || pwr_tick;
      if (state_r == adx_pkg::S_CBR_RAS && wait_done && !init_full)
        init_cnt_r <= init_cnt_r + adx_pkg::INIT_W'(1);
      rsp_valid_r <= last_col;
      if (last_col && !wr_r)
        rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r <= 1'h0;
      be_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
    end
    else if (taken)
    begin
      wr_r <= req_write;
      be_r <= req_be;
      addr_r <= req_addr;
      wdata_r <= req_wdata;
    end
  end

  assign req_ready = req_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rdata_r;
  assign init_done = req_ready_r;
  assign pins = pins_r;
  assign dq_out = wdata_r;
  assign dq_oe = dq_oe_r;

  // Helper: cycles since the row strobe was last active
  logic [15:0] ras_idle_r;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ras_idle_r <= '0;
    else if (!pins_r.ras_n || !pwr_done_r)
      ras_idle_r <= '0;
    else if (ras_idle_r != 16'hffff)
      ras_idle_r <= ras_idle_r + 16'h0001;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_pause_before_ras: assert property ($fell(pins_r.ras_n) |-> $past(pwr_done_r, 2))
    else $error("row strobe before power-up pause ended");
  a_init_eight_cbr: assert property ($rose(req_ready_r) |-> init_full)
    else $error("accepting requests before eight refresh cycles");
  a_refresh_served: assert property ($rose(ref_pend_r) |-> ##[1:20] !ref_pend_r)
    else $error("refresh request not served in time");
  a_ras_idle_bound: assert property (ras_idle_r <= 16'(REF_CYC + 20))
    else $error("row strobe idle too long");
  a_cbr_cas_first: assert property ($fell(pins_r.ras_n) && !pins_r.lower_col_strobe_n
    |-> $past(!pins_r.lower_col_strobe_n && !pins_r.upper_col_strobe_n))
    else $error("column strobes not ahead of row strobe in refresh");
  a_row_addr_held: assert property ($fell(pins_r.ras_n) && pins_r.lower_col_strobe_n
    && pins_r.upper_col_strobe_n |-> $stable(pins_r.addr))
    else $error("row address changed at row strobe fall");
  a_col_addr_held: assert property ($fell(pins_r.lower_col_strobe_n && pins_r.upper_col_strobe_n)
    && !pins_r.ras_n |-> $stable(pins_r.addr) ##1 $stable(pins_r.addr))
    else $error("column address not held across column strobe fall");
  a_early_write_we: assert property ((|dq_oe_r) && $fell(pins_r.lower_col_strobe_n
    && pins_r.upper_col_strobe_n) |-> $past(!pins_r.we_n))
    else $error("write select not ahead of column strobe");
  a_no_bus_fight: assert property (!pins_r.oe_n |-> dq_oe_r == '0)
    else $error("controller drives lanes while output gate active");
  a_lane_strobe_match: assert property ((|dq_oe_r) && !pins_r.ras_n && !pins_r.we_n
    |-> !(dq_oe_r[0] && pins_r.lower_col_strobe_n && state_r == adx_pkg::S_COL_ACT))
    else $error("low lane driven without lower strobe");

endmodule

// ---- test/adx_mem_model.sv ----
`timescale 1ns/1ns
module adx_mem_model (
  input wire logic sys_clk,
  input wire adx_pkg::adx_pins_s pins,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe,
  output logic [15:0] dq_in,
  output int cbr_cnt,
  output int first_ns,
  output int err_cnt
);
  logic [15:0] mem [int];
  logic [9:0] row_r = 10'h000;
  logic cbr_r = 1'h0;
  logic [15:0] rd_word = 16'h0000;
  logic [15:0] float_r = 16'h5a5a;
  logic [19:0] a;
  logic [15:0] w;
  wire logic [1:0] cas_act = ~{pins.upper_col_strobe_n, pins.lower_col_strobe_n};
  wire logic rd_on = !pins.ras_n && !cbr_r && !pins.oe_n && pins.we_n;
  int cbr_n = 0;
  int first_n = 0;
  int e_drv = 0;
  int e_wr = 0;
  int e_we = 0;
  assign cbr_cnt = cbr_n;
  assign first_ns = first_n;
  assign err_cnt = e_drv + e_wr + e_we;
  // Open lanes show a pattern flipping every cycle
  always @*
  begin
    for (int i = 0; i < 2; i++)
      dq_in[i*8+:8] = (rd_on && cas_act[i]) ? rd_word[i*8+:8] : float_r[i*8+:8];
  end
  always @(posedge sys_clk)
  begin
    float_r <= ~dq_in;
    if (rd_on && |(cas_act & dq_oe))
      e_drv <= e_drv + 1;
  end
  always @(negedge pins.ras_n)
  begin
    if (&cas_act)
    begin
      // Hidden refresh with output gate on keeps the last read word
      cbr_r = pins.oe_n || !pins.we_n;
      cbr_n = cbr_n + 1;
      if (first_n == 0)
        first_n = int'($time);
    end
    else
    begin
      cbr_r = 1'h0;
      row_r = pins.addr;
    end
  end
  always @(negedge pins.lower_col_strobe_n or negedge pins.upper_col_strobe_n)
  begin
    if (!pins.ras_n && !cbr_r)
    begin
      a = {row_r, pins.addr};
      w = mem.exists(a) ? mem[a] : 16'h0000;
      if (!pins.we_n)
      begin
        for (int i = 0; i < 2; i++)
          if (cas_act[i])
          begin
            w[i*8+:8] = dq_out[i*8+:8];
            if (!dq_oe[i])
              e_wr = e_wr + 1;
          end
        mem[a] = w;
      end
      else
        rd_word = w;
    end
  end
  // Write select falling after column strobe is not an early write
  always @(negedge pins.we_n)
    if (!pins.ras_n && |cas_act)
      e_we = e_we + 1;
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
  localparam int PWR = 20;
  localparam int REFC = 60;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic [1:0] req_be = 2'h3;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, rsp_valid, init_done;
  logic [15:0] rsp_rdata, dq_in, dq_out;
  logic [1:0] dq_oe;
  adx_pkg::adx_pins_s pins;
  int cbr_cnt, first_ns, err_cnt, rel_ns, c0, n;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] seed = 16'h001e;
  logic [15:0] ref_m [int];
  logic [19:0] pool [8];
  adx_dram_ctrl #(.PWRUP_CYC(PWR), .REF_CYC(REFC)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_be(req_be),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  adx_mem_model i_mem (.sys_clk(sys_clk), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .cbr_cnt(cbr_cnt), .first_ns(first_ns), .err_cnt(err_cnt));
  always #10 sys_clk = ~sys_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_rd(input logic [15:0] d, input logic [1:0] be);
    return {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00};
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_ge(input int got, input int lo, input string msg);
    n_tests++;
    if (got < lo)
    begin
      miscompares++;
      $display("Error at %0t: %s %0d below %0d", $time, msg, got, lo);
    end
  endtask
  // Caller enters just after a rising edge
  task automatic access(input logic w, input logic [1:0] be, input logic [19:0] a,
    input logic [15:0] d);
    int k;
    req_write = w;
    req_be = be;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'h1;
    k = 0;
    while (req_ready !== 1'h1 && k < 400)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    @(posedge sys_clk);
    #1;
    req_valid = 1'h0;
    k = 0;
    while (rsp_valid !== 1'h1 && k < 40)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk16({15'h0000, rsp_valid}, 16'h0001, "no response");
    if (w)
      ref_m[a] = (ref_m[a] & ~exp_rd(16'hffff, be)) | exp_rd(d, be);
    else
      chk16(rsp_rdata, exp_rd(ref_m[a], be), "read data");
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1;
    chk16({1'h0, pins}, {1'h0, adx_pkg::PINS_IDLE}, "reset pins");
    chk16({13'h0000, dq_oe, req_ready}, 16'h0000, "reset drive");
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'h1;
    rel_ns = int'($time);
    n = 0;
    while (init_done !== 1'h1 && n < 1000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_ge(cbr_cnt, 8, "init cycles");
    chk_ge(first_ns - rel_ns, PWR * 20, "pause");
    pool[0] = 20'h00000;
    pool[1] = 20'hfffff;
    pool[2] = 20'h003ff;
    pool[3] = 20'hffc00;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      if (i > 3)
        pool[i] = {seed[9:0], seed[15:6]};
      ref_m[pool[i]] = 16'h0000;
      access(1'h1, 2'h3, pool[i], seed);
    end
    for (int i = 0; i < 60; i++)
    begin
      seed = lfsr(seed);
      access(seed[7], (seed[5:4] == 2'h0) ? 2'h3 : seed[5:4], pool[seed[2:0]], lfsr(seed));
    end
    c0 = cbr_cnt;
    repeat (10 * REFC) @(posedge sys_clk);
    #1;
    chk_ge(cbr_cnt - c0, 9, "refresh rate");
    chk_ge(0 - err_cnt, 0, "lane drive or late write");
    give_verdict();
  end
endmodule
